//--- core/faal_params.svh
`ifndef FAAL_PARAMS_SVH
`define FAAL_PARAMS_SVH
// Pin-function field positions (two bits each).
`define FAAL_PF_ALERT_LSB  0
`define FAAL_PF_FULLON_LSB 2
`define FAAL_PF_SYNC_LSB   4
// Pin-function codes.
`define FAAL_PF_OUT_LOW    2'h2
`define FAAL_PF_OUT_HIGH   2'h3
`define FAAL_PF_SPECIAL    2'h1
`define FAAL_PF_CLK_IN     2'h0
// Pin-function reset value: every general pin is an output high.
`define FAAL_PF_RESET      6'h3F
// Alarm bit positions, shared by enable and status.
`define FAAL_AL_MINOUT     0
`define FAAL_AL_MAXOUT     1
`define FAAL_AL_TACHOVF    2
`define FAAL_AL_PIN1LOW    3
`define FAAL_AL_PIN2LOW    4
`define FAAL_AL_RESET      5'h00
// Converter codes that mark saturation.
`define FAAL_DRIVE_MIN     8'h00
`define FAAL_DRIVE_MAX     8'hFF
// Tachometer counter full count.
`define FAAL_TACH_FULL     8'hFF
// Closed-loop mode code in configuration bits 5:4.
`define FAAL_MODE_LSB      4
`define FAAL_MODE_CLOSED   2'h2
// Reference clock divider: 250 MHz / 1000 = 250 kHz.
`define FAAL_REF_DIV       10'd500
`endif

//--- core/faal_pkg.sv
package faal_pkg;
  // Alarm vector type; one bit per alarm source.
  typedef logic [4:0] faal_alarm_t;
  // Release handshake states of the status read.
  typedef enum logic [1:0] {
    FAAL_IDLE = 2'b01,
    FAAL_READ = 2'b10
  } faal_rd_t;
endpackage

//--- core/faal_tach_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "faal_params.svh"
// Counts tachometer pulses over a window and saturates at the full count.
module faal_tach_counter (
  input  wire logic       ref_clk,   // System clock.
  input  wire logic       rst,       // Asynchronous reset, active high.
  input  wire logic       pulseIn,   // Tachometer level input.
  input  wire logic       windowEnd, // One-cycle pulse that restarts the count.
  output logic [7:0]      count_reg, // Running pulse count.
  output logic            full_reg   // High while the count sits at full.
);
  logic pulseDly_reg; // Previous pulse level for edge detection.

  // Edge detector register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulseDly_reg <= 1'b0;
    end else begin
      pulseDly_reg <= pulseIn;
    end
  end

  // The counter stops at its full count instead of wrapping.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 8'h00;
    end else if (windowEnd) begin
      count_reg <= 8'h00;
    end else if (pulseIn && !pulseDly_reg && count_reg != `FAAL_TACH_FULL) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // Full flag follows the counter one cycle later.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_reg <= 1'b0;
    end else begin
      full_reg <= (count_reg == `FAAL_TACH_FULL);
    end
  end
endmodule
`default_nettype wire

//--- core/fan_alarm_alert_logic.sv
`timescale 1ns/100ps
`default_nettype none
`include "faal_params.svh"
// How it works
// - Enabled alarm drives alert pin low.
// - Pin-function 1:0 = 01 makes pin zero alert.
// - Override low forces full fan voltage.
// - Pin-function 3:2 = 01 makes pin one override.
// - Pin-function 5:4 = 01 outputs reference clock.
// - Pin-function 5:4 = 00 takes external clock.
// - Converter code 00h raises minimum alarm.
// - Converter code FFh raises maximum alarm.
// - Enable bits 0 and 1 gate saturation alarms.
// - Any full tachometer counter raises overflow alarm.
// - Enable bit 2 gates overflow alarm.
// - Low pin one or two alarms, any function.
// - Enable bits 3 and 4 gate pin alarms.
// - Alert stays latched after condition ends.
// - Status read releases only ended conditions.
// - Clearing enable bit releases its alert.
// - Status register records the alarm cause.
// - Tachometer counter saturates at full count.
// - Configuration 5:4 = 10 selects closed loop.
module fan_alarm_alert_logic (
  input  wire logic       ref_clk,          // System clock, 250 MHz.
  input  wire logic       rst,              // Asynchronous reset, active high.
  input  wire logic [5:0] pinFunction,      // Pin-function selections, two bits per pin.
  input  wire logic [4:0] alarmEnable,      // Alarm enable bits.
  input  wire logic       statusRead,       // One-cycle pulse: software read the status.
  input  wire logic [5:0] configMode,       // Configuration bits; 5:4 hold the mode.
  input  wire logic [7:0] driveCode,        // Converter code from the loop regulator.
  input  wire logic [3:0] speedPulseIn,     // Tachometer inputs; bit 0 is speed_pulse_in_zero.
  input  wire logic       tachWindowEnd,    // One-cycle pulse ending a count window.
  input  wire logic       genPinZeroIn,     // Level seen on general pin zero.
  input  wire logic       genPinOneIn,      // Level seen on general pin one.
  input  wire logic       genPinTwoIn,      // Level seen on general pin two.
  output logic            genPinZeroOut,    // Pin zero output value (always low when driven).
  output logic            genPinZeroOe,     // Pin zero pull-down enable.
  output logic            genPinOneOut,     // Pin one output value.
  output logic            genPinOneOe,      // Pin one pull-down enable.
  output logic            genPinTwoOut,     // Pin two output value.
  output logic            genPinTwoOe,      // Pin two pull-down enable.
  output logic [4:0]      alarmStatus,      // Latched alarm status bits.
  output logic            alertActive,      // High while the alert is asserted.
  output logic            fullOnForce,      // High while the override forces full voltage.
  output logic            closedLoop,       // High while closed-loop regulation is selected.
  output logic            refClkTick,       // One-cycle reference clock pulse in use.
  output logic [31:0]     tachCounts        // Four saturating counts, counter 0 in low byte.
);
  faal_pkg::faal_alarm_t cond;              // Live alarm conditions.
  faal_pkg::faal_alarm_t status_reg;        // Sticky status bits.
  faal_pkg::faal_alarm_t status_next;       // Next status value.
  faal_pkg::faal_rd_t    rdState_reg;       // Status read phase.
  logic [3:0]            tachFull;          // Full flags of the counters.
  logic [9:0]            refDiv_reg;        // Reference clock divider.
  logic                  refLevel_reg;      // Internal reference clock level.
  logic                  extDly_reg;        // Previous external clock level.
  logic                  alert_reg;         // Alert asserted.
  logic                  pin0Oe_reg;        // Registered pin zero enable.
  logic                  pin1Oe_reg;        // Registered pin one enable.
  logic                  pin2Oe_reg;        // Registered pin two enable.
  logic                  fullOn_reg;        // Registered override.
  logic                  closed_reg;        // Registered mode decode.
  logic                  tick_reg;          // Registered reference tick.
  logic [31:0]           counts;            // Gathered counter values.

  // Returns true when a two-bit field of the pin-function word holds the code.
  function automatic logic fieldIs(input logic [5:0] word, input int lsb, input logic [1:0] code);
    logic [1:0] f;
    f = word[lsb +: 2];
    return f == code;
  endfunction

  // One saturating counter per tachometer input.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gTach
      faal_tach_counter uCnt (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pulseIn   (speedPulseIn[gi]),
        .windowEnd (tachWindowEnd),
        .count_reg (counts[gi*8 +: 8]),
        .full_reg  (tachFull[gi])
      );
    end
  endgenerate

  // Live conditions; status bits share the enable bit positions.
  always_comb begin
    cond = 5'h00;
    cond[`FAAL_AL_MINOUT]  = (driveCode == `FAAL_DRIVE_MIN);
    cond[`FAAL_AL_MAXOUT]  = (driveCode == `FAAL_DRIVE_MAX);
    cond[`FAAL_AL_TACHOVF] = |tachFull;
    cond[`FAAL_AL_PIN1LOW] = !genPinOneIn;
    cond[`FAAL_AL_PIN2LOW] = !genPinTwoIn;
  end

  // Status latching: set wins over the read clear, and a disabled alarm drops out.
  always_comb begin
    status_next = status_reg;
    if (rdState_reg == faal_pkg::FAAL_READ) begin
      status_next = status_reg & cond;
    end
    status_next = (status_next | cond) & alarmEnable;
  end

  // Status register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_reg <= `FAAL_AL_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Read phase: the clear applies the cycle after the read pulse.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdState_reg <= faal_pkg::FAAL_IDLE;
    end else begin
      case (rdState_reg)
        faal_pkg::FAAL_IDLE: begin
          if (statusRead) begin
            rdState_reg <= faal_pkg::FAAL_READ;
          end
        end
        faal_pkg::FAAL_READ: begin
          rdState_reg <= statusRead ? faal_pkg::FAAL_READ : faal_pkg::FAAL_IDLE;
        end
        default: begin
          rdState_reg <= faal_pkg::FAAL_IDLE;
        end
      endcase
    end
  end

  // Alert follows any latched enabled alarm.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= |status_next;
    end
  end

  // Internal reference clock divider.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      refDiv_reg   <= 10'd0;
      refLevel_reg <= 1'b0;
    end else if (refDiv_reg == `FAAL_REF_DIV - 10'd1) begin
      refDiv_reg   <= 10'd0;
      refLevel_reg <= !refLevel_reg;
    end else begin
      refDiv_reg <= refDiv_reg + 10'd1;
    end
  end

  // Reference tick: internal rising edge, or external clock rising edge when pin two is an input.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extDly_reg <= 1'b1; // Matches the pulled-up idle level so no false edge follows reset.
      tick_reg   <= 1'b0;
    end else begin
      extDly_reg <= genPinTwoIn;
      if (fieldIs(pinFunction, `FAAL_PF_SYNC_LSB, `FAAL_PF_CLK_IN)) begin
        tick_reg <= genPinTwoIn && !extDly_reg;
      end else begin
        tick_reg <= (refDiv_reg == `FAAL_REF_DIV - 10'd1) && !refLevel_reg;
      end
    end
  end

  // Pin drivers: open drain, enable high pulls the pin low.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin0Oe_reg <= 1'b0;
      pin1Oe_reg <= 1'b0;
      pin2Oe_reg <= 1'b0;
    end else begin
      if (fieldIs(pinFunction, `FAAL_PF_ALERT_LSB, `FAAL_PF_SPECIAL)) begin
        pin0Oe_reg <= |status_next;
      end else begin
        pin0Oe_reg <= fieldIs(pinFunction, `FAAL_PF_ALERT_LSB, `FAAL_PF_OUT_LOW);
      end
      pin1Oe_reg <= fieldIs(pinFunction, `FAAL_PF_FULLON_LSB, `FAAL_PF_OUT_LOW);
      if (fieldIs(pinFunction, `FAAL_PF_SYNC_LSB, `FAAL_PF_SPECIAL)) begin
        pin2Oe_reg <= !refLevel_reg;
      end else begin
        pin2Oe_reg <= fieldIs(pinFunction, `FAAL_PF_SYNC_LSB, `FAAL_PF_OUT_LOW);
      end
    end
  end

  // Override and mode decode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fullOn_reg <= 1'b0;
      closed_reg <= 1'b0;
    end else begin
      fullOn_reg <= fieldIs(pinFunction, `FAAL_PF_FULLON_LSB, `FAAL_PF_SPECIAL) && !genPinOneIn;
      closed_reg <= (configMode[`FAAL_MODE_LSB +: 2] == `FAAL_MODE_CLOSED);
    end
  end

  assign genPinZeroOut = 1'b0;
  assign genPinOneOut  = 1'b0;
  assign genPinTwoOut  = 1'b0;
  assign genPinZeroOe  = pin0Oe_reg;
  assign genPinOneOe   = pin1Oe_reg;
  assign genPinTwoOe   = pin2Oe_reg;
  assign alarmStatus   = status_reg;
  assign alertActive   = alert_reg;
  assign fullOnForce   = fullOn_reg;
  assign closedLoop    = closed_reg;
  assign refClkTick    = tick_reg;
  assign tachCounts    = counts;
endmodule
`default_nettype wire

//--- bench/faal_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Checks alarm latching and pin behaviour at the block's ports.
module faal_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [5:0]  pinFunction,
  input wire logic [4:0]  alarmEnable,
  input wire logic        statusRead,
  input wire logic [7:0]  driveCode,
  input wire logic        genPinOneIn,
  input wire logic        genPinZeroOe,
  input wire logic [4:0]  alarmStatus,
  input wire logic        alertActive,
  input wire logic        fullOnForce,
  input wire logic [31:0] tachCounts
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_minSet; alarmEnable[0] && driveCode == 8'h00 |=> alarmStatus[0]; endproperty
  a_minSet: assert property (p_minSet) else $error("min alarm missed");
  property p_maxSet; alarmEnable[1] && driveCode == 8'hFF |=> alarmStatus[1] && alertActive; endproperty
  a_maxSet: assert property (p_maxSet) else $error("max alarm missed");
  property p_alertPin;
    pinFunction[1:0] == 2'h1 && $past(pinFunction[1:0]) == 2'h1 |-> genPinZeroOe == alertActive;
  endproperty
  a_alertPin: assert property (p_alertPin) else $error("alert pin wrong");
  property p_full; pinFunction[3:2] == 2'h1 && !genPinOneIn |=> fullOnForce; endproperty
  a_full: assert property (p_full) else $error("override missed");
  property p_pinLow; alarmEnable[3] && !genPinOneIn |=> alarmStatus[3]; endproperty
  a_pinLow: assert property (p_pinLow) else $error("pin alarm missed");
  property p_tachOvf; (alarmEnable[2] && tachCounts[7:0] == 8'hFF) [*2] |=> alarmStatus[2]; endproperty
  a_tachOvf: assert property (p_tachOvf) else $error("overflow missed");
  property p_latch; alarmStatus[0] && alarmEnable[0] && !$past(statusRead) |=> alarmStatus[0]; endproperty
  a_latch: assert property (p_latch) else $error("status lost");
  property p_disable; (alarmEnable == 5'h00) [*2] |-> !alertActive && alarmStatus == 5'h00; endproperty
  a_disable: assert property (p_disable) else $error("alert kept");
  // Main scenarios: alert raised, read then released, override taken.
  c_alert: cover property (alertActive);
  c_read: cover property (statusRead ##2 !alertActive);
  c_full: cover property (fullOnForce);
endmodule
bind fan_alarm_alert_logic faal_monitor mon (.ref_clk, .rst, .pinFunction, .alarmEnable, .statusRead, .driveCode,
  .genPinOneIn, .genPinZeroOe, .alarmStatus, .alertActive, .fullOnForce, .tachCounts);
`default_nettype wire

//--- bench/faal_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host that answers a low alert line by reading the status.
module faal_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       alertPinN,
  input  wire logic       serviceEn,
  input  wire logic [3:0] waitCycles,
  input  wire logic [4:0] alarmStatus,
  output var  logic       statusRead,
  output var  logic [4:0] lastStatus
);
  int wt = 0;
  initial statusRead = 1'h0;
  initial lastStatus = 5'h00;
  // Reads once the alert waited long enough, so reads stay apart.
  always @(negedge ref_clk) begin
    if (!rst && serviceEn && !alertPinN && wt >= int'(waitCycles) + 4) begin
      statusRead <= 1'h1;
      wt <= 0;
    end else begin
      statusRead <= 1'h0;
      wt <= (!rst && serviceEn && !alertPinN) ? wt + 1 : 0;
    end
  end
  // Keeps the cause that the read returned.
  always @(posedge ref_clk) begin
    if (statusRead) lastStatus <= alarmStatus;
  end
endmodule
`default_nettype wire

//--- bench/fan_alarm_alert_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Drives the alarm block, mirrors it in a model and compares each cycle.
module fan_alarm_alert_logic_tb;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  logic [5:0]  pinFunction = 6'h3F;
  logic [4:0]  alarmEnable = 5'h00;
  logic [5:0]  configMode = 6'h00;
  logic [7:0]  driveCode = 8'h80;
  logic [3:0]  speedPulseIn = 4'h0;
  logic        tachWindowEnd = 1'h0;
  logic        pinOneDrv = 1'h1;
  logic        pinTwoDrv = 1'h1;
  logic        serviceEn = 1'h0;
  logic [3:0]  waitCycles = 4'h0;
  logic        chkOn = 1'h0;
  logic        statusRead, genPinZeroOe, genPinOneOe, genPinTwoOe, alertActive, fullOnForce, closedLoop, refClkTick;
  logic        genPinOneIn, genPinTwoIn, mA, mOe, mOe1, mFull, mLoop, ovf;
  logic [4:0]  alarmStatus, lastStatus, mSt, nSt, mLast, cnd;
  logic [3:0]  nxt;
  logic [31:0] tachCounts;
  int          errorCnt = 0;
  int          compares = 0;
  int          ticks = 0;
  int          rises [4] = '{0, 0, 0, 0};
  int          i;
  int          k;
  always #2 ref_clk = ~ref_clk;
  // Open-drain pins are high unless someone pulls them low.
  assign genPinOneIn = pinOneDrv & ~genPinOneOe;
  assign genPinTwoIn = pinTwoDrv & ~genPinTwoOe;
  assign cnd = {~genPinTwoIn, ~genPinOneIn, 1'h0, driveCode == 8'hFF, driveCode == 8'h00};
  assign nSt = ((mA ? mSt & cnd : mSt) | cnd) & alarmEnable & 5'h1B;
  fan_alarm_alert_logic dut (.ref_clk, .rst, .pinFunction, .alarmEnable, .statusRead, .configMode, .driveCode,
    .speedPulseIn, .tachWindowEnd, .genPinZeroIn(~genPinZeroOe), .genPinOneIn, .genPinTwoIn, .genPinZeroOut(),
    .genPinZeroOe, .genPinOneOut(), .genPinOneOe, .genPinTwoOut(), .genPinTwoOe, .alarmStatus, .alertActive,
    .fullOnForce, .closedLoop, .refClkTick, .tachCounts);
  faal_host_model host (.ref_clk, .rst, .alertPinN(~genPinZeroOe), .serviceEn, .waitCycles, .alarmStatus,
    .statusRead, .lastStatus);
  // Model of latched status, alert pin, override and mode.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {mSt, mA, mOe, mOe1, mFull, mLoop} <= '0;
      mLast <= 5'h00;
    end else begin
      mA <= statusRead;
      mSt <= nSt;
      mOe <= pinFunction[1:0] == 2'h1 ? |nSt : pinFunction[1:0] == 2'h2;
      mOe1 <= pinFunction[3:2] == 2'h2;
      mFull <= pinFunction[3:2] == 2'h1 && !genPinOneIn;
      mLoop <= configMode[5:4] == 2'h2;
      if (statusRead) mLast <= mSt;
      if (refClkTick) ticks <= ticks + 1;
    end
  end
  // Counts a comparison and reports a mismatch.
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("Comparisons %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Compares design and model half a cycle after each edge.
  always @(negedge ref_clk) begin
    if (chkOn) begin
      check("satStatus", mSt[2:0], alarmStatus[2:0]);
      check("pinStatus", mSt[4:3], alarmStatus[4:3]);
      check("alert", {|mSt, mOe}, {alertActive, genPinZeroOe});
      check("mode", {mFull, mLoop}, {fullOnForce, closedLoop});
      check("cause", mLast & 5'h1B, lastStatus & 5'h1B);
      check("pinOneOe", mOe1, genPinOneOe);
    end
  end
  initial begin
    void'($urandom(32'h3514));
    cyc(16);
    rst = 1'h0;
    chkOn = 1'h1;
    // Saturation codes, with prompt, slow or absent service.
    for (i = 0; i < 8; i++) begin
      pinFunction = {4'hF, 2'(1 + $urandom % 3)};
      waitCycles = 4'($urandom);
      alarmEnable = 5'($urandom) & 5'h18 | 5'h03;
      serviceEn = i[1];
      driveCode = i[0] ? 8'hFF : 8'h00;
      cyc(3);
      if (!i[2]) driveCode = 8'(1 + $urandom % 254);
      cyc(30);
      alarmEnable = 5'h00;
      cyc(3);
    end
    $display("Saturation test done");
    // Pins pulled low at random under every pin one and pin two function, pin zero as alert, and every mode code.
    for (i = 0; i < 16; i++) begin
      pinFunction = {i[3:0], 2'h1};
      configMode = {i[1:0], 4'($urandom)};
      alarmEnable = 5'($urandom) & 5'h18;
      pinOneDrv = 1'($urandom);
      pinTwoDrv = 1'($urandom);
      cyc(4);
      pinOneDrv = 1'h1;
      pinTwoDrv = 1'h1;
      cyc(30);
    end
    $display("Pin test done");
    // Random pulses on all counters; counts saturate at full.
    chkOn = 1'h0;
    serviceEn = 1'h0;
    alarmEnable = 5'h04;
    for (i = 0; i < 1100; i++) begin
      nxt = 4'($urandom);
      for (k = 0; k < 4; k++) if (nxt[k] && !speedPulseIn[k]) rises[k]++;
      speedPulseIn = nxt;
      cyc(2);
    end
    cyc(4);
    ovf = 1'h0;
    for (k = 0; k < 4; k++) begin
      ovf = ovf | rises[k] >= 255;
      check("count", 16'(rises[k] > 255 ? 255 : rises[k]), 16'(tachCounts[8*k +: 8]));
    end
    check("overflow", 16'(ovf), 16'(alarmStatus[2]));
    tachWindowEnd = 1'h1;
    cyc(1);
    tachWindowEnd = 1'h0;
    alarmEnable = 5'h00;
    cyc(3);
    check("cleared", 16'h0, 16'(|tachCounts));
    chkOn = 1'h1;
    $display("Tach test done");
    // Closed loop on the internal clock, then with pin two as the clock input.
    configMode = 6'h20;
    pinFunction = 6'h1F;
    cyc(4);
    ticks = 0;
    cyc(2000);
    check("intTicks", 16'h2, 16'(ticks));
    pinFunction = 6'h0F;
    cyc(8);
    ticks = 0;
    repeat (6) begin
      pinTwoDrv = 1'h0;
      cyc(10);
      pinTwoDrv = 1'h1;
      cyc(10);
    end
    check("extTicks", 16'h6, 16'(ticks));
    $display("Sync test done");
    results();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #80000;
    errorCnt++;
    $display("Watchdog expired");
    results();
  end
endmodule
`default_nettype wire
